// >>> src/link_shifter.sv
// Purpose: Serial-clock side shift register and frame capture
// Assumes: sclk only toggles while a frame is open or stands still
// Notes: Word is read in the mclk domain only once synced cs_n is high
`timescale 1ns/1ns
module link_shifter #(
    parameter int WIDTH = 18
) (
    input wire logic sclk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic serial_in,
    output logic [WIDTH-1:0] shift_out
);
    logic [WIDTH-1:0] shift_reg;
    logic [WIDTH-1:0] shift_next;

    always_comb begin
        shift_next = shift_reg;
        if (!cs_n) begin
            shift_next = {shift_reg[WIDTH-2:0], serial_in};
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= shift_next;
        end
    end

    assign shift_out = shift_reg;
endmodule // link_shifter

// >>> src/quad_dac_serial_word_loader.sv
// Purpose: Serial command path loading four channel input registers
// Assumes: mclk much faster than the serial clock; cs_n is a pin
// Notes: Load happens a few mclk cycles after cs_n rises
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Word shifted in most significant bit first
// - Top two bits select, low sixteen code
// - Only last eighteen bits examined at close
// - Chip select rise loads code to channel
// - Select 00=A, 01=B, 10=C, 11=D
// - Load strobe low makes converter registers transparent
// - Shift only on rising clock with select low
// - Preset forces registers to zero or half
// - Power-up reset sets zero or half scale
module quad_dac_serial_word_loader #(
    parameter int CHANNELS = word_loader_pkg::CHANNELS
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic converter_load_strobe_n,
    input wire logic preset_n,
    input wire logic half_scale_sel,
    output logic [15:0] input_code [CHANNELS],
    output logic [15:0] converter_code [CHANNELS],
    output logic load_pulse
);
    localparam int W = word_loader_pkg::WORD_BITS;
    localparam int SETTLE = word_loader_pkg::STRAP_SETTLE;

    logic [W-1:0] link_word;
    word_loader_pkg::cmd_word_t cmd;

    // Shift register sits in the serial clock domain
    link_shifter #(
        .WIDTH(W)
    ) u_shift (
        .sclk(sclk),
        .rst_n(rst_n),
        .cs_n(cs_n),
        .serial_in(serial_in),
        .shift_out(link_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, three stages, change when stages two and three agree
    logic [2:0] cs_sync_reg, cs_sync_next;
    logic [2:0] ld_sync_reg, ld_sync_next;
    logic [2:0] ps_sync_reg, ps_sync_next;
    logic [2:0] hs_sync_reg, hs_sync_next;
    logic cs_level_reg, cs_level_next;
    logic ld_level_reg, ld_level_next;
    logic ps_level_reg, ps_level_next;
    logic hs_level_reg, hs_level_next;

    always_comb begin
        cs_sync_next = {cs_sync_reg[1:0], cs_n};
        ld_sync_next = {ld_sync_reg[1:0], converter_load_strobe_n};
        ps_sync_next = {ps_sync_reg[1:0], preset_n};
        hs_sync_next = {hs_sync_reg[1:0], half_scale_sel};
        cs_level_next = (cs_sync_reg[1] == cs_sync_reg[2]) ? cs_sync_reg[2] : cs_level_reg;
        ld_level_next = (ld_sync_reg[1] == ld_sync_reg[2]) ? ld_sync_reg[2] : ld_level_reg;
        ps_level_next = (ps_sync_reg[1] == ps_sync_reg[2]) ? ps_sync_reg[2] : ps_level_reg;
        hs_level_next = (hs_sync_reg[1] == hs_sync_reg[2]) ? hs_sync_reg[2] : hs_level_reg;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_reg <= 3'h7;
            ld_sync_reg <= 3'h7;
            ps_sync_reg <= 3'h7;
            hs_sync_reg <= 3'h0;
            cs_level_reg <= 1'b1;
            ld_level_reg <= 1'b1;
            ps_level_reg <= 1'b1;
            hs_level_reg <= 1'b0;
        end else begin
            cs_sync_reg <= cs_sync_next;
            ld_sync_reg <= ld_sync_next;
            ps_sync_reg <= ps_sync_next;
            hs_sync_reg <= hs_sync_next;
            cs_level_reg <= cs_level_next;
            ld_level_reg <= ld_level_next;
            ps_level_reg <= ps_level_next;
            hs_level_reg <= hs_level_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame close detect; word is stable since sclk stops while cs_n is high
    word_loader_pkg::load_state_t st_reg, st_next;
    logic [W-1:0] word_reg, word_next;
    logic load_next;
    logic load_reg;

    always_comb begin
        st_next = st_reg;
        word_next = word_reg;
        load_next = 1'b0;
        case (st_reg)
            word_loader_pkg::LD_IDLE: begin
                if (!cs_level_reg) begin
                    st_next = word_loader_pkg::LD_WAIT;
                end
            end
            word_loader_pkg::LD_WAIT: begin
                if (cs_level_reg) begin
                    // Only the last W bits survive in the shifter
                    word_next = link_word;
                    load_next = 1'b1;
                    st_next = word_loader_pkg::LD_IDLE;
                end
            end
            default: st_next = word_loader_pkg::LD_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= word_loader_pkg::LD_IDLE;
            word_reg <= '0;
            load_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            word_reg <= word_next;
            load_reg <= load_next;
        end
    end

    assign cmd = word_loader_pkg::cmd_word_t'(word_reg);
    assign load_pulse = load_reg;

    ////////////////////////////////////////////////////////////////////////
    // Power-up settle; a high strap would be missed if preset ended early
    logic init_reg;
    logic init_next;
    logic [SETTLE-1:0] settle_reg;
    logic [SETTLE-1:0] settle_next;

    always_comb begin
        settle_next = {settle_reg[SETTLE-2:0], 1'b1};
        init_next = init_reg | settle_reg[SETTLE-1];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            settle_reg <= '0;
            init_reg <= 1'b0;
        end else begin
            settle_reg <= settle_next;
            init_reg <= init_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input and converter registers
    logic [15:0] in_reg [CHANNELS];
    logic [15:0] in_next [CHANNELS];
    logic [15:0] cv_reg [CHANNELS];
    logic [15:0] cv_next [CHANNELS];
    logic [15:0] preset_code;
    logic [1:0] target;

    assign preset_code = hs_level_reg ? word_loader_pkg::HALF_CODE
                                      : word_loader_pkg::ZERO_CODE;
    assign target = {cmd.channel_sel_hi, cmd.channel_sel_lo};

    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            in_next[i] = in_reg[i];
            cv_next[i] = cv_reg[i];
            if (!init_reg || !ps_level_reg) begin
                // Preset beats any load in the same cycle
                in_next[i] = preset_code;
                cv_next[i] = preset_code;
            end else begin
                if (load_reg && target == i[1:0]) begin
                    in_next[i] = cmd.code_bits;
                end
                if (!ld_level_reg) begin
                    cv_next[i] = in_reg[i];
                end
            end
        end
    end

    // Strap level sampled after release, so power-up value follows it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < CHANNELS; i++) begin
                in_reg[i] <= word_loader_pkg::ZERO_CODE;
                cv_reg[i] <= word_loader_pkg::ZERO_CODE;
            end
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                in_reg[i] <= in_next[i];
                cv_reg[i] <= cv_next[i];
            end
        end
    end

    assign input_code = in_reg;
    assign converter_code = cv_reg;
endmodule // quad_dac_serial_word_loader

// >>> src/word_loader_pkg.sv
// Purpose: Shared constants and types for the quad converter word loader
// Assumes: 18-bit frames, two select bits above a 16-bit code
// Notes: Used as word_loader_pkg::name, never imported
package word_loader_pkg;
    localparam int WORD_BITS = 18;
    localparam int CODE_BITS = 16;
    localparam int SEL_HI_POS = 17;
    localparam int SEL_LO_POS = 16;
    localparam int CODE_MSB = 15;
    localparam int CHANNELS = 4;
    // Edges after reset before the strap level is trusted
    localparam int STRAP_SETTLE = 4;
    localparam logic [15:0] ZERO_CODE = 16'h0000;
    localparam logic [15:0] HALF_CODE = 16'h8000;
    localparam logic [1:0] CH_A = 2'h0;
    localparam logic [1:0] CH_B = 2'h1;
    localparam logic [1:0] CH_C = 2'h2;
    localparam logic [1:0] CH_D = 2'h3;

    typedef struct packed {
        logic channel_sel_hi;
        logic channel_sel_lo;
        logic [15:0] code_bits;
    } cmd_word_t;

    typedef struct packed {
        logic [1:0] channel;
        logic [15:0] code;
    } load_req_t;

    typedef enum logic [1:0] {
        LD_IDLE = 2'b01,
        LD_WAIT = 2'b10
    } load_state_t;
endpackage

// >>> verif/serial_host_model.sv
// Purpose: Serial master that frames command words
// Assumes: 64 ns link clock, rising edge samples
// Notes: Clock stands low between frames
`timescale 1ns/1ns
module serial_host_model (
    output logic sclk,
    output logic cs_n,
    output logic serial_in
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
    end
    task automatic send(input logic [31:0] w, input int n);
        #3 cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = w[i];
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
        end
        #32 cs_n = 1'b1;
        serial_in = ~serial_in; // Idle data never holds the last bit
    endtask
endmodule // serial_host_model

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the word loader
// Assumes: Reset, strobe, preset and strap change on mclk falling edge; host serial pins change between mclk edges
// Notes: Expected codes kept in exp_in and exp_cv
`timescale 1ns/1ns
module tb_top;
    logic mclk, rst_n, sclk, cs_n, serial_in, load_pulse;
    logic converter_load_strobe_n, preset_n, half_scale_sel;
    logic [15:0] input_code [4];
    logic [15:0] converter_code [4];
    logic [15:0] exp_in [4];
    logic [15:0] exp_cv [4];
    logic [15:0] cw [4] = '{16'hffff, 16'h0001, 16'h8000, 16'h7ffe};
    int bad_count = 0;
    int check_count = 0;
    quad_dac_serial_word_loader u_dut (.mclk, .rst_n, .sclk, .cs_n, .serial_in,
        .converter_load_strobe_n, .preset_n, .half_scale_sel, .input_code,
        .converter_code, .load_pulse);
    serial_host_model u_host (.sclk, .cs_n, .serial_in);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic check_all;
        for (int k = 0; k < 4; k++) begin
            check("input_code", input_code[k], exp_in[k]);
            check("converter_code", converter_code[k], exp_cv[k]);
        end
    endtask
    task automatic frame(input logic [31:0] w, input int n);
        @(negedge mclk);
        u_host.send(w, n);
        // Bounded wait: a lost load must not hang the run
        for (int i = 0; i < 20 && load_pulse !== 1'b1; i++) @(negedge mclk);
        check("load_pulse", {15'h0000, load_pulse}, 16'h0001);
        repeat (3) @(negedge mclk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #40000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        rst_n = 1'b0;
        converter_load_strobe_n = 1'b1;
        preset_n = 1'b1;
        half_scale_sel = 1'b0;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        repeat (12) @(negedge mclk);
        exp_in = '{default: 16'h0000};
        exp_cv = exp_in;
        check_all();
        for (int k = 0; k < 4; k++) begin
            frame({k[1:0], cw[k]}, 18);
            exp_in[k] = cw[k];
            check_all();
        end
        frame({4'hf, 2'h1, 16'h3c3c}, 22);
        exp_in[1] = 16'h3c3c;
        check_all();
        converter_load_strobe_n = 1'b0;
        repeat (10) @(negedge mclk);
        exp_cv = exp_in;
        check_all();
        frame({2'h3, 16'h0f0f}, 18);
        exp_in[3] = 16'h0f0f;
        exp_cv[3] = 16'h0f0f;
        check_all();
        converter_load_strobe_n = 1'b1;
        for (int h = 1; h >= 0; h--) begin
            half_scale_sel = h[0];
            preset_n = 1'b0;
            repeat (10) @(negedge mclk);
            preset_n = 1'b1;
            repeat (6) @(negedge mclk);
            exp_in = '{default: (h == 1) ? 16'h8000 : 16'h0000};
            exp_cv = exp_in;
            check_all();
        end
        // Mid-run reset with a high strap: all registers come up half scale
        half_scale_sel = 1'b1;
        rst_n = 1'b0;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        repeat (12) @(negedge mclk);
        exp_in = '{default: 16'h8000};
        exp_cv = exp_in;
        check_all();
        frame({2'h2, 16'h1234}, 18);
        exp_in[2] = 16'h1234;
        check_all();
        tally_and_finish();
    end
endmodule // tb_top

// >>> verif/word_loader_assertions.sv
// Purpose: Port-level checks for the quad converter word loader
// Assumes: No sclk edges while cs_n is high
// Notes: Shadow shifter mirrors the link side
`timescale 1ns/1ns
module word_loader_assertions #(
    parameter int CHANNELS = word_loader_pkg::CHANNELS
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic converter_load_strobe_n,
    input wire logic preset_n,
    input wire logic half_scale_sel,
    input wire logic [15:0] input_code [CHANNELS],
    input wire logic [15:0] converter_code [CHANNELS],
    input wire logic load_pulse
);
    logic [17:0] sh_reg;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Unreset: only compared after a full frame
    always_ff @(posedge sclk) begin
        if (!cs_n) sh_reg <= {sh_reg[16:0], serial_in};
    end
    ////////////////////////////////////////////////////////////////////////
    a_pulse_single: assert property (load_pulse |=> !load_pulse)
        else $error("load pulse longer than one cycle");
    a_pulse_cause: assert property (load_pulse |-> cs_n && $past(cs_n, 2))
        else $error("load pulse without chip select rise");
    a_rise_loads: assert property ($rose(cs_n) |-> ##[2:8] load_pulse)
        else $error("chip select rise gave no load");
    a_decode_load: assert property (load_pulse |=>
        input_code[sh_reg[17:16]] == sh_reg[15:0]) else $error("wrong channel or code loaded");
    a_preset_code: assert property ((!preset_n && $stable(half_scale_sel))[*8] |->
        input_code[0] == (half_scale_sel ? 16'h8000 : 16'h0000))
        else $error("preset code wrong");
    a_conv_follow: assert property ((!converter_load_strobe_n && preset_n)[*8] |->
        converter_code[1] == $past(input_code[1]))
        else $error("converter register not transparent");
    a_conv_latch: assert property ((converter_load_strobe_n && preset_n)[*8] |->
        $stable(converter_code[2]))
        else $error("converter register not latched");
    a_power_up: assert property ($rose(rst_n) |-> ##8
        input_code[2] == (half_scale_sel ? 16'h8000 : 16'h0000))
        else $error("power-up code wrong");
endmodule // word_loader_assertions
bind quad_dac_serial_word_loader word_loader_assertions #(.CHANNELS(CHANNELS)) u_chk (
    .mclk, .rst_n, .sclk, .cs_n, .serial_in, .converter_load_strobe_n, .preset_n,
    .half_scale_sel, .input_code, .converter_code, .load_pulse);
